// ===== shared/tpu_pkg.sv
// Functional notes
// - Hold 8-bit staged value for groups 1/0; copy to port A latch on trigger.
// - Hold 8-bit staged value for groups 3/2; copy to port B latch on trigger.
// - Low-pair staging clears on reset and hardware standby; software standby keeps it.
// - High-pair staging clears on reset and hardware standby; software standby keeps it.
// - Groups 0/1 same trigger: whole low-pair register at first address.
// - Groups 0/1 same trigger: group 0 alternate address ignores writes, reads ones.
// - Groups 0/1 split triggers: group 1 nibble first address, group 0 alternate.
// - Split 0/1: unused nibbles at both addresses ignore writes, read ones.
// - Groups 2/3 same trigger: whole high-pair register at first address.
// - Groups 2/3 same trigger: group 2 alternate address ignores writes, reads ones.
// - Groups 2/3 split triggers: group 3 nibble first address, group 2 alternate.
// - Split 2/3: unused nibbles at both addresses ignore writes, read ones.
// - Enabled pins 7-0 take staged bit into port A latch on compare match.
// - Disabled pins 7-0 are not copied; port A value unchanged.
// - Enabled pins 15-8 take staged bit into port B latch on compare match.
// - Disabled pins 15-8 are not copied; port B value unchanged.
// - Low-pin enables clear on reset and hardware standby, kept in software standby.
// - High-pin enables clear on reset and hardware standby, kept in software standby.
// - Enable and staged bits 15-8 map in order onto port B bits 7-0.
// - Port latch bits with transfer enabled ignore software writes.
// - Per-group 2-bit trigger select: 00 channel 0, 01 channel 1, 1x channel 2.
// - Normal-mode group updates at compare match A of its selected channel.
package tpu_pkg;

  localparam int unsigned IDX_W = 20;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MODE      = 20'hfffa0;
  localparam logic [IDX_W-1:0] IDX_TRIG_SEL  = 20'hfffa1;
  localparam logic [IDX_W-1:0] IDX_EN_HIGH   = 20'hfffa2;
  localparam logic [IDX_W-1:0] IDX_EN_LOW    = 20'hfffa3;
  localparam logic [IDX_W-1:0] IDX_NP_HIGH   = 20'hfffa4;
  localparam logic [IDX_W-1:0] IDX_NP_LOW    = 20'hfffa5;
  localparam logic [IDX_W-1:0] IDX_NP_G2_ALT = 20'hfffa6;
  localparam logic [IDX_W-1:0] IDX_NP_G0_ALT = 20'hfffa7;
  localparam logic [IDX_W-1:0] IDX_PORT_A    = 20'hfffd9;
  localparam logic [IDX_W-1:0] IDX_PORT_B    = 20'hfffda;

  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_TRIG_SEL = 8'hff;
  localparam logic [7:0] RST_MODE     = 8'hf0;
  localparam logic [7:0] MODE_FIXED   = 8'hf0;
  localparam logic [3:0] NIB_ONES     = 4'hf;
  localparam logic [7:0] BYTE_ONES    = 8'hff;

  // Trigger select field positions, low bit of each group's field
  localparam int unsigned SEL_G0 = 0;
  localparam int unsigned SEL_G1 = 2;
  localparam int unsigned SEL_G2 = 4;
  localparam int unsigned SEL_G3 = 6;

  // Mode register: non-overlap flag bit per group
  localparam int unsigned NOV_G0 = 0;
  localparam int unsigned NOV_G1 = 1;
  localparam int unsigned NOV_G2 = 2;
  localparam int unsigned NOV_G3 = 3;

  localparam int unsigned SYNC_STAGES = 2;

endpackage : tpu_pkg

// ===== logic/tpu_staging.sv
`timescale 1ns/1ns
module tpu_staging
  import tpu_pkg::*;
#(
  parameter int unsigned ADDR_W = 22
)
(
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              hw_standby,
  input  wire logic [2:0]        compare_match_a,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [15:0]            pattern_out_pin
);

  logic [1:0]       rst_sync;
  logic             rst_n_int;
  logic [1:0]       standby_sync;
  logic             standby;
  logic             clear;

  logic [7:0]       next_pattern_low_pair;
  logic [7:0]       next_pattern_high_pair;
  logic [7:0]       transfer_enable_low_pins;
  logic [7:0]       transfer_enable_high_pins;
  logic [7:0]       trigger_select_control;
  logic [3:0]       overlap_mode_control;
  logic [7:0]       port_a_output_latch;
  logic [7:0]       port_b_output_latch;

  logic [IDX_W-1:0] idx;
  logic             wr;
  logic [7:0]       wdata;
  logic             same_low;
  logic             same_high;
  logic [3:0]       fire;
  logic [7:0]       take_a;
  logic [7:0]       take_b;
  logic [7:0]       next_rdata;
  logic             next_err;

  // Reset release through two flops
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n_int = rst_sync[1];

  // Standby pin is asynchronous to this clock
  always_ff @(posedge clock or negedge rst_n_int)
  begin
    if (!rst_n_int)
      standby_sync <= 2'b00;
    else
      standby_sync <= {standby_sync[0], hw_standby};
  end
  assign standby = standby_sync[1];
  assign clear   = standby;

  function automatic logic [1:0] chan(input logic [1:0] sel);
    chan = sel[1] ? 2'd2 : {1'b0, sel[0]};
  endfunction : chan

  // Normal mode fires on match A
  function automatic logic hit(input logic [1:0] sel,
                               input logic       nov,
                               input logic [2:0] cm);
    hit = !nov && cm[chan(sel)];
  endfunction : hit

  assign same_low  = chan(trigger_select_control[SEL_G0 +: 2]) ==
                     chan(trigger_select_control[SEL_G1 +: 2]);
  assign same_high = chan(trigger_select_control[SEL_G2 +: 2]) ==
                     chan(trigger_select_control[SEL_G3 +: 2]);

  // Pulse used on its own sampling edge
  assign fire[0] = hit(trigger_select_control[SEL_G0 +: 2],
                       overlap_mode_control[NOV_G0], compare_match_a);
  assign fire[1] = hit(trigger_select_control[SEL_G1 +: 2],
                       overlap_mode_control[NOV_G1], compare_match_a);
  assign fire[2] = hit(trigger_select_control[SEL_G2 +: 2],
                       overlap_mode_control[NOV_G2], compare_match_a);
  assign fire[3] = hit(trigger_select_control[SEL_G3 +: 2],
                       overlap_mode_control[NOV_G3], compare_match_a);

  assign take_a = transfer_enable_low_pins &
                  {{4{fire[1]}}, {4{fire[0]}}};
  // Bit order kept one to one
  assign take_b = transfer_enable_high_pins &
                  {{4{fire[3]}}, {4{fire[2]}}};

  assign idx   = paddr[IDX_W+1:2];
  assign wr    = psel && penable && pwrite;
  assign wdata = pwdata[7:0];

  // Staging, low pair
  always_ff @(posedge clock or negedge rst_n_int)
  begin
    if (!rst_n_int)
      next_pattern_low_pair <= RST_ZERO;
    else if (clear)
      next_pattern_low_pair <= RST_ZERO;
    else if (wr && idx == IDX_NP_LOW)
    begin
      if (same_low)
        next_pattern_low_pair <= wdata;
      else
        next_pattern_low_pair[7:4] <= wdata[7:4];
    end
    else if (wr && idx == IDX_NP_G0_ALT && !same_low)
      next_pattern_low_pair[3:0] <= wdata[3:0];
  end

  // Staging, high pair
  always_ff @(posedge clock or negedge rst_n_int)
  begin
    if (!rst_n_int)
      next_pattern_high_pair <= RST_ZERO;
    else if (clear)
      next_pattern_high_pair <= RST_ZERO;
    else if (wr && idx == IDX_NP_HIGH)
    begin
      if (same_high)
        next_pattern_high_pair <= wdata;
      else
        next_pattern_high_pair[7:4] <= wdata[7:4];
    end
    else if (wr && idx == IDX_NP_G2_ALT && !same_high)
      next_pattern_high_pair[3:0] <= wdata[3:0];
  end

  // Enable registers
  always_ff @(posedge clock or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      transfer_enable_low_pins  <= RST_ZERO;
      transfer_enable_high_pins <= RST_ZERO;
    end
    else if (clear)
    begin
      transfer_enable_low_pins  <= RST_ZERO;
      transfer_enable_high_pins <= RST_ZERO;
    end
    else if (wr && idx == IDX_EN_LOW)
      transfer_enable_low_pins <= wdata;
    else if (wr && idx == IDX_EN_HIGH)
      transfer_enable_high_pins <= wdata;
  end

  // Trigger select and mode
  always_ff @(posedge clock or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      trigger_select_control <= RST_TRIG_SEL;
      overlap_mode_control   <= RST_MODE[3:0];
    end
    else if (clear)
    begin
      trigger_select_control <= RST_TRIG_SEL;
      overlap_mode_control   <= RST_MODE[3:0];
    end
    else if (wr && idx == IDX_TRIG_SEL)
      trigger_select_control <= wdata;
    else if (wr && idx == IDX_MODE)
      overlap_mode_control <= wdata[3:0];
  end

  // Port latches; write and transfer never touch the same bit
  always_ff @(posedge clock or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      port_a_output_latch <= RST_ZERO;
      port_b_output_latch <= RST_ZERO;
    end
    else if (clear)
    begin
      port_a_output_latch <= RST_ZERO;
      port_b_output_latch <= RST_ZERO;
    end
    else
    begin
      if (wr && idx == IDX_PORT_A)
        port_a_output_latch <=
          (port_a_output_latch & ~take_a & transfer_enable_low_pins) |
          (wdata & ~transfer_enable_low_pins) |
          (next_pattern_low_pair & take_a);
      else
        port_a_output_latch <= (port_a_output_latch & ~take_a) |
                               (next_pattern_low_pair & take_a);
      if (wr && idx == IDX_PORT_B)
        port_b_output_latch <=
          (port_b_output_latch & ~take_b & transfer_enable_high_pins) |
          (wdata & ~transfer_enable_high_pins) |
          (next_pattern_high_pair & take_b);
      else
        port_b_output_latch <= (port_b_output_latch & ~take_b) |
                               (next_pattern_high_pair & take_b);
    end
  end

  assign pattern_out_pin = {port_b_output_latch, port_a_output_latch};

  // Read mux; unmapped index answers with an error
  always_comb
  begin
    next_rdata = RST_ZERO;
    next_err   = 1'b0;
    unique case (idx)
      IDX_MODE:      next_rdata = MODE_FIXED | {4'h0, overlap_mode_control};
      IDX_TRIG_SEL:  next_rdata = trigger_select_control;
      IDX_EN_HIGH:   next_rdata = transfer_enable_high_pins;
      IDX_EN_LOW:    next_rdata = transfer_enable_low_pins;
      IDX_NP_LOW:    next_rdata = same_low ? next_pattern_low_pair :
                        {next_pattern_low_pair[7:4], NIB_ONES};
      IDX_NP_G0_ALT: next_rdata = same_low ? BYTE_ONES :
                        {NIB_ONES, next_pattern_low_pair[3:0]};
      IDX_NP_HIGH:   next_rdata = same_high ? next_pattern_high_pair :
                        {next_pattern_high_pair[7:4], NIB_ONES};
      IDX_NP_G2_ALT: next_rdata = same_high ? BYTE_ONES :
                        {NIB_ONES, next_pattern_high_pair[3:0]};
      IDX_PORT_A:    next_rdata = port_a_output_latch;
      IDX_PORT_B:    next_rdata = port_b_output_latch;
      default:       next_err   = 1'b1;
    endcase
  end

  // Read data captured in setup so it comes from a flop
  always_ff @(posedge clock or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata  <= {24'h00_0000, next_rdata};
      pslverr <= next_err;
    end
  end

  // One wait-free access phase
  assign pready = penable;

endmodule : tpu_staging

// ===== bench/tpu_staging_asserts.sv
`timescale 1ns/1ns
module tpu_staging_asserts
  import tpu_pkg::*;
#(
  parameter int unsigned ADDR_W = 22
)
(
  input wire logic              clock,
  input wire logic              rstn,
  input wire logic              hw_standby,
  input wire logic [2:0]        compare_match_a,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [15:0]       pattern_out_pin
);
  logic [7:0] en_lo;
  logic [7:0] en_hi;
  logic       wr;
  logic       rd_setup;

  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  // Enable shadow; stale after standby, which only weakens the checks
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      en_lo <= 8'h00;
    else if (wr && paddr == {IDX_EN_LOW, 2'b00})
      en_lo <= pwdata[7:0];
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      en_hi <= 8'h00;
    else if (wr && paddr == {IDX_EN_HIGH, 2'b00})
      en_hi <= pwdata[7:0];
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn || hw_standby);

  property p_rd_upper;
    rd_setup |=> prdata[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("read data above bit 7 not zero");

  property p_alt_a;
    rd_setup && paddr == {IDX_NP_G0_ALT, 2'b00} |=> prdata[7:4] == NIB_ONES;
  endproperty
  a_alt_a: assert property (p_alt_a)
    else $error("group 0 alternate upper nibble not ones");

  property p_alt_b;
    rd_setup && paddr == {IDX_NP_G2_ALT, 2'b00} |=> prdata[7:4] == NIB_ONES;
  endproperty
  a_alt_b: assert property (p_alt_b)
    else $error("group 2 alternate upper nibble not ones");

  property p_map;
    rd_setup && paddr == {IDX_NP_LOW, 2'b00} |=> !pslverr;
  endproperty
  a_map: assert property (p_map)
    else $error("staging address refused");

  property p_hold;
    !wr && compare_match_a == 3'b000 |=> $stable(pattern_out_pin);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pins moved without compare pulse");

  property p_dis_a;
    !wr |=> ((pattern_out_pin[7:0] ^ $past(pattern_out_pin[7:0]))
             & ~$past(en_lo)) == 8'h00;
  endproperty
  a_dis_a: assert property (p_dis_a)
    else $error("disabled port A bit changed");

  property p_dis_b;
    !wr |=> ((pattern_out_pin[15:8] ^ $past(pattern_out_pin[15:8]))
             & ~$past(en_hi)) == 8'h00;
  endproperty
  a_dis_b: assert property (p_dis_b)
    else $error("disabled port B bit changed");

  property p_stby;
    disable iff (!rstn) hw_standby [*4] |=> pattern_out_pin == 16'h0000;
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby left pins set");
endmodule : tpu_staging_asserts

bind tpu_staging tpu_staging_asserts #(.ADDR_W(ADDR_W)) i_chk (
  .clock(clock), .rstn(rstn), .hw_standby(hw_standby),
  .compare_match_a(compare_match_a), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pattern_out_pin(pattern_out_pin)
);

// ===== bench/tpu_timer_model.sv
`timescale 1ns/1ns
module tpu_timer_model
(
  input  wire logic clock,
  output logic [2:0] compare_match_a
);
  initial compare_match_a = 3'b000;

  // Pulse width one clock; lag models a slow timer
  task automatic fire(input logic [2:0] ch, input int unsigned lag);
    repeat (lag) @(posedge clock);
    compare_match_a <= ch;
    @(posedge clock);
    compare_match_a <= 3'b000;
  endtask : fire
endmodule : tpu_timer_model

// ===== bench/tpu_staging_test.sv
`timescale 1ns/1ns
module tpu_staging_test;
  import tpu_pkg::*;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        hw_standby = 1'b0;
  logic [2:0]  cm;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [21:0] paddr = 22'h000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] pins;
  logic        err;
  logic [7:0]  rd;
  int          fails = 0;
  int          tests_run = 0;
  logic [19:0] zidx [4] = '{IDX_NP_HIGH, IDX_NP_LOW, IDX_EN_HIGH, IDX_EN_LOW};

  always #2 clock = ~clock;

  tpu_timer_model i_tmr (.clock(clock), .compare_match_a(cm));

  tpu_staging i_dut (
    .clock(clock), .rstn(rstn), .hw_standby(hw_standby),
    .compare_match_a(cm), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pattern_out_pin(pins)
  );

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : check

  // Leaves the bus selected so a next setup may follow at once
  task automatic apb(input logic [19:0] idx, input logic w,
                     input logic [7:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata[7:0];
    err = pslverr;
    if (pready !== 1'b1)
    begin
      fails++;
      end_of_test();
    end
  endtask : apb

  task automatic rdc(input logic [19:0] idx, input logic [7:0] exp);
    apb(idx, 1'b0, 8'h00);
    check($sformatf("reg %h", idx), {8'h00, rd}, {8'h00, exp});
  endtask : rdc

  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : idle

  task automatic fire(input logic [2:0] ch, input int unsigned lag,
                      input logic [15:0] exp);
    idle();
    i_tmr.fire(ch, lag);
    @(posedge clock);
    check("pins", pins, exp);
  endtask : fire

  task automatic zeros;
    for (int i = 0; i < 4; i++)
      rdc(zidx[i], RST_ZERO);
    rdc(IDX_TRIG_SEL, RST_TRIG_SEL);
  endtask : zeros

  initial
  begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    zeros();
    $display("test reset done");
    apb(IDX_NP_LOW, 1'b1, 8'ha5);
    apb(IDX_NP_HIGH, 1'b1, 8'h3c);
    apb(IDX_NP_G0_ALT, 1'b1, 8'h00);
    apb(IDX_NP_G2_ALT, 1'b1, 8'h00);
    rdc(IDX_NP_LOW, 8'ha5);
    rdc(IDX_NP_HIGH, 8'h3c);
    rdc(IDX_NP_G0_ALT, BYTE_ONES);
    rdc(IDX_NP_G2_ALT, BYTE_ONES);
    apb(IDX_EN_LOW, 1'b1, 8'h0f);
    apb(IDX_EN_HIGH, 1'b1, 8'hf0);
    fire(3'b001, 0, 16'h0000);
    fire(3'b100, 3, 16'h3005);
    $display("test shared done");
    apb(IDX_TRIG_SEL, 1'b1, 8'h48);
    apb(IDX_NP_LOW, 1'b1, 8'h5a);
    apb(IDX_NP_G0_ALT, 1'b1, 8'h3c);
    apb(IDX_NP_HIGH, 1'b1, 8'h96);
    apb(IDX_NP_G2_ALT, 1'b1, 8'he1);
    rdc(IDX_NP_LOW, 8'h5f);
    rdc(IDX_NP_G0_ALT, 8'hfc);
    rdc(IDX_NP_HIGH, 8'h9f);
    rdc(IDX_NP_G2_ALT, 8'hf1);
    apb(IDX_EN_LOW, 1'b1, 8'hff);
    apb(IDX_EN_HIGH, 1'b1, 8'hff);
    fire(3'b001, 0, 16'h310c);
    fire(3'b100, 0, 16'h315c);
    fire(3'b010, 1, 16'h915c);
    $display("test split done");
    apb(IDX_EN_LOW, 1'b1, 8'h0f);
    apb(IDX_PORT_A, 1'b1, 8'h00);
    rdc(IDX_PORT_A, 8'h0c);
    apb(IDX_EN_HIGH, 1'b1, 8'h0f);
    apb(IDX_PORT_B, 1'b1, 8'h00);
    rdc(IDX_PORT_B, 8'h01);
    apb(IDX_NP_G0_ALT, 1'b1, 8'h03);
    apb(IDX_MODE, 1'b1, 8'h01);
    rdc(IDX_MODE, 8'hf1);
    fire(3'b001, 0, 16'h010c);
    apb(20'hfffa8, 1'b0, 8'h00);
    check("slverr", {15'h0000, err}, 16'h0001);
    $display("test latch done");
    idle();
    hw_standby <= 1'b1;
    repeat (6) @(posedge clock);
    hw_standby <= 1'b0;
    repeat (4) @(posedge clock);
    check("pins", pins, 16'h0000);
    zeros();
    $display("test standby done");
    idle();
    end_of_test();
  end
endmodule : tpu_staging_test
